// >>> common/dbu_pkg.sv
package dbu_pkg;

   // register byte offsets
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] FMT_OFS = 8'h04;
   localparam logic [7:0] FLAGS_OFS = 8'h14;
   localparam logic [7:0] RXHOLD_OFS = 8'h18;
   localparam logic [7:0] DIV_OFS = 8'h20;

   // command register bit positions
   localparam int RX_ABORT_BIT = 2;
   localparam int RX_ON_BIT = 4;
   localparam int RX_OFF_BIT = 5;
   localparam int FLAGS_CLR_BIT = 8;

   // format register fields
   localparam int PAR_LSB = 9;
   localparam int PAR_W = 3;
   localparam int FORCE_TRST_BIT = 16;

   // flags register bit positions
   localparam int READY_BIT = 0;
   localparam int OVERRUN_BIT = 5;
   localparam int FRAME_BIT = 6;
   localparam int PARERR_BIT = 7;

   // parity selections
   localparam logic [2:0] PAR_EVEN = 3'h0;
   localparam logic [2:0] PAR_ODD = 3'h1;
   localparam logic [2:0] PAR_SPACE = 3'h2;
   localparam logic [2:0] PAR_MARK = 3'h3;
   localparam logic [2:0] PAR_NONE = 3'h4;

   // values after reset
   localparam logic [2:0] PAR_RST = 3'h0;
   localparam logic [15:0] DIV_RST = 16'h0000;

   // counts of sampling ticks and the index of the last data bit
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
   localparam logic [4:0] START_MIN_TICKS = 5'h07;
   localparam logic [4:0] FIRST_SAMPLE_TICKS = 5'h18;
   localparam logic [4:0] BIT_TICKS = 5'h10;
   localparam logic [2:0] LAST_DATA_BIT = 3'h7;

   typedef enum logic [2:0] {
      RX_OFF = 3'b000,
      RX_HUNT = 3'b001,
      RX_START = 3'b011,
      RX_DATA = 3'b010,
      RX_PARITY = 3'b110,
      RX_STOP = 3'b111
   } dbu_rx_state_type;

   typedef struct packed {
      logic ready;
      logic overrun;
      logic parity_err;
      logic frame_err;
   } dbu_flags_type;

   typedef struct packed {
      logic [2:0] parity_select;
      logic force_test_reset;
   } dbu_format_type;

   // parity bit the line should carry for this data and selection
   function automatic logic parity_expect(input logic [7:0] data,
                                          input logic [2:0] sel);
      logic p;
      p = 1'b0;
      case (sel)
         PAR_EVEN: p = ^data;
         PAR_ODD: p = ~(^data);
         PAR_SPACE: p = 1'b0;
         PAR_MARK: p = 1'b1;
         default: p = 1'b0;
      endcase
      return p;
   endfunction

endpackage

// >>> design/dbu_baud_gen.sv
`timescale 1ns/1ps
module dbu_baud_gen (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // divisor
   input wire logic [15:0] baud_divisor,
   // ticks
   output logic sample_tick,
   output logic baud_tick
);

   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [3:0] sub_r;
   logic [3:0] sub_nxt;
   logic sample_r;
   logic sample_nxt;
   logic baud_r;
   logic baud_nxt;

   always_comb
   begin
      count_nxt = count_r;
      sub_nxt = sub_r;
      sample_nxt = 1'b0;
      baud_nxt = 1'b0;
      // (RQ2) zero stops clock
      if (baud_divisor == 16'h0000)
      begin
         count_nxt = 16'h0000;
         sub_nxt = 4'h0;
      end
      // (RQ20) reload down-counter
      else if (count_r == 16'h0000)
      begin
         count_nxt = baud_divisor - 16'h0001;
         sample_nxt = 1'b1;
         // (RQ1) further divide by 16
         sub_nxt = sub_r + 4'h1;
         baud_nxt = (sub_r == dbu_pkg::OVERSAMPLE_LAST);
      end
      else
      begin
         // (RQ3) any divisor counts down
         count_nxt = count_r - 16'h0001;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         count_r <= 16'h0000;
         sub_r <= 4'h0;
         sample_r <= 1'b0;
         baud_r <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         sub_r <= sub_nxt;
         sample_r <= sample_nxt;
         baud_r <= baud_nxt;
      end
   end

   assign sample_tick = sample_r;
   assign baud_tick = baud_r;

endmodule

// >>> design/dbu_rx_sync.sv
`timescale 1ns/1ps
module dbu_rx_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // pin and cleaned level
   input wire logic pin_in,
   output logic level_out
);

   logic [2:0] sync_r;
   logic [2:0] sync_nxt;
   logic level_r;
   logic level_nxt;

   // idle line is high, so reset to high to avoid a false start
   always_comb
   begin
      sync_nxt = {sync_r[1:0], pin_in};
      level_nxt = level_r;
      if (sync_r[1] == sync_r[2])
      begin
         level_nxt = sync_r[2];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         sync_r <= 3'b111;
         level_r <= 1'b1;
      end
      else
      begin
         sync_r <= sync_nxt;
         level_r <= level_nxt;
      end
   end

   assign level_out = level_r;

endmodule

// >>> design/dbu_debug_uart.sv
// Operation
// (RQ1) baud clock is master over 16 times divisor
// (RQ2) divisor zero stops the whole port; the code stops only the sample and baud ticks
// (RQ3) divisors span 1 to 65535 steps
// (RQ4) receiver disabled after reset
// (RQ5) enable command starts start-bit search
// (RQ6) disable stops now or after stop bit
// (RQ7) abort command drops character and disables; a character ending in the abort cycle is still held and flagged ready
// (RQ8) start bit needs low over 7 ticks
// (RQ9) first sample 24 ticks after edge
// (RQ10) later samples every 16 ticks
// (RQ11) async frames, eight data bits, optional parity
// (RQ12) no receive timeout, no time guard
// (RQ13) even, odd, mark, space parity choices
// (RQ14) flag parity, framing and overrun errors
// (RQ15) software can force emulator test reset
// (RQ16) completed character sets ready, read clears
// (RQ17) overrun sticky until flags clear command
// (RQ18) parity mismatch flagged with ready
// (RQ19) zero stop bit flags framing error
// (RQ20) divider is 16-bit reloaded down-counter
`timescale 1ns/1ps
module dbu_debug_uart (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line
   input wire logic serial_rx_line,
   // baud clock for the transmitter side
   output logic baud_tick,
   // debug access block
   output logic emulator_test_reset_force
);

   logic rx_level;
   logic sample_tick;
   logic [7:0] addr;
   logic mapped;
   logic wr_acc;
   logic rd_setup;
   logic rd_hold_acc;
   logic cmd_on;
   logic cmd_off;
   logic cmd_abort;
   logic cmd_clr;
   logic [31:0] rdata;

   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic [15:0] baud_divisor_reg_r;
   logic [15:0] baud_divisor_reg_nxt;
   dbu_pkg::dbu_format_type fmt_r;
   dbu_pkg::dbu_format_type fmt_nxt;

   dbu_pkg::dbu_rx_state_type st_r;
   dbu_pkg::dbu_rx_state_type st_nxt;
   logic en_r;
   logic en_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic [4:0] cnt_inc;
   logic [2:0] bit_r;
   logic [2:0] bit_nxt;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic par_bit_r;
   logic par_bit_nxt;
   logic [7:0] hold_r;
   logic [7:0] hold_nxt;
   dbu_pkg::dbu_flags_type flags_r;
   dbu_pkg::dbu_flags_type flags_nxt;

   dbu_rx_sync u_rx_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pin_in(serial_rx_line),
      .level_out(rx_level)
   );

   dbu_baud_gen u_baud_gen (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .baud_divisor(baud_divisor_reg_r),
      .sample_tick(sample_tick),
      .baud_tick(baud_tick)
   );

   // bus decode
   assign addr = paddr[7:0];
   // (RQ12) no timeout or guard registers
   assign mapped = (paddr[31:8] == 24'h000000) && (addr[1:0] == 2'b00) &&
                   ((addr == dbu_pkg::CMD_OFS) ||
                    (addr == dbu_pkg::FMT_OFS) ||
                    (addr == dbu_pkg::FLAGS_OFS) ||
                    (addr == dbu_pkg::RXHOLD_OFS) ||
                    (addr == dbu_pkg::DIV_OFS));
   assign wr_acc = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign rd_hold_acc = psel && penable && !pwrite &&
                        (addr == dbu_pkg::RXHOLD_OFS) && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // commands are one-cycle pulses on a control write
   assign cmd_on = wr_acc && (addr == dbu_pkg::CMD_OFS) &&
                   pwdata[dbu_pkg::RX_ON_BIT];
   assign cmd_off = wr_acc && (addr == dbu_pkg::CMD_OFS) &&
                    pwdata[dbu_pkg::RX_OFF_BIT];
   assign cmd_abort = wr_acc && (addr == dbu_pkg::CMD_OFS) &&
                      pwdata[dbu_pkg::RX_ABORT_BIT];
   assign cmd_clr = wr_acc && (addr == dbu_pkg::CMD_OFS) &&
                    pwdata[dbu_pkg::FLAGS_CLR_BIT];

   // read mux, captured in the setup cycle so prdata is a flop
   always_comb
   begin
      rdata = 32'h00000000;
      if (mapped)
      begin
         case (addr)
            dbu_pkg::FMT_OFS:
            begin
               rdata[dbu_pkg::PAR_LSB +: dbu_pkg::PAR_W] = fmt_r.parity_select;
               rdata[dbu_pkg::FORCE_TRST_BIT] = fmt_r.force_test_reset;
            end
            dbu_pkg::FLAGS_OFS:
            begin
               rdata[dbu_pkg::READY_BIT] = flags_r.ready;
               rdata[dbu_pkg::OVERRUN_BIT] = flags_r.overrun;
               rdata[dbu_pkg::FRAME_BIT] = flags_r.frame_err;
               rdata[dbu_pkg::PARERR_BIT] = flags_r.parity_err;
            end
            dbu_pkg::RXHOLD_OFS: rdata[7:0] = hold_r;
            dbu_pkg::DIV_OFS: rdata[15:0] = baud_divisor_reg_r;
            default: rdata = 32'h00000000;
         endcase
      end
   end

   // configuration registers
   always_comb
   begin
      prdata_nxt = prdata_r;
      baud_divisor_reg_nxt = baud_divisor_reg_r;
      fmt_nxt = fmt_r;
      if (rd_setup)
      begin
         prdata_nxt = rdata;
      end
      if (wr_acc && (addr == dbu_pkg::DIV_OFS))
      begin
         baud_divisor_reg_nxt = pwdata[15:0];
      end
      if (wr_acc && (addr == dbu_pkg::FMT_OFS))
      begin
         // (RQ13) parity selection stored
         fmt_nxt.parity_select = pwdata[dbu_pkg::PAR_LSB +: dbu_pkg::PAR_W];
         fmt_nxt.force_test_reset = pwdata[dbu_pkg::FORCE_TRST_BIT];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         prdata_r <= 32'h00000000;
         baud_divisor_reg_r <= dbu_pkg::DIV_RST;
         fmt_r.parity_select <= dbu_pkg::PAR_RST;
         fmt_r.force_test_reset <= 1'b0;
      end
      else
      begin
         prdata_r <= prdata_nxt;
         baud_divisor_reg_r <= baud_divisor_reg_nxt;
         fmt_r <= fmt_nxt;
      end
   end

   assign prdata = prdata_r;
   // (RQ15) force test reset output
   assign emulator_test_reset_force = fmt_r.force_test_reset;

   // receiver
   assign cnt_inc = cnt_r + 5'h01;

   always_comb
   begin
      st_nxt = st_r;
      en_nxt = en_r;
      cnt_nxt = cnt_r;
      bit_nxt = bit_r;
      shift_nxt = shift_r;
      par_bit_nxt = par_bit_r;
      hold_nxt = hold_r;
      flags_nxt = flags_r;
      // (RQ16) holding read clears ready
      if (rd_hold_acc)
      begin
         flags_nxt.ready = 1'b0;
      end
      // (RQ17) clear command drops sticky errors
      if (cmd_clr)
      begin
         flags_nxt.overrun = 1'b0;
         flags_nxt.parity_err = 1'b0;
         flags_nxt.frame_err = 1'b0;
      end
      // disable wins when both commands arrive together
      if (cmd_on)
      begin
         en_nxt = 1'b1;
      end
      if (cmd_off)
      begin
         en_nxt = 1'b0;
      end
      case (st_r)
         dbu_pkg::RX_OFF:
         begin
            // (RQ5) enable starts the search
            if (en_nxt)
            begin
               st_nxt = dbu_pkg::RX_HUNT;
            end
         end
         dbu_pkg::RX_HUNT:
         begin
            // (RQ6) idle disable stops at once
            if (!en_nxt)
            begin
               st_nxt = dbu_pkg::RX_OFF;
            end
            else if (sample_tick && !rx_level)
            begin
               st_nxt = dbu_pkg::RX_START;
               cnt_nxt = 5'h00;
            end
         end
         dbu_pkg::RX_START:
         begin
            if (sample_tick)
            begin
               // (RQ8) short low is a glitch
               if (rx_level && (cnt_inc <= dbu_pkg::START_MIN_TICKS))
               begin
                  st_nxt = dbu_pkg::RX_HUNT;
               end
               // (RQ9) first sample at 24 ticks
               else if (cnt_inc == dbu_pkg::FIRST_SAMPLE_TICKS)
               begin
                  shift_nxt = {rx_level, shift_r[7:1]};
                  bit_nxt = 3'h1;
                  cnt_nxt = 5'h00;
                  st_nxt = dbu_pkg::RX_DATA;
               end
               else
               begin
                  cnt_nxt = cnt_inc;
               end
            end
         end
         dbu_pkg::RX_DATA:
         begin
            // (RQ10) one sample per 16 ticks
            if (sample_tick)
            begin
               cnt_nxt = cnt_inc;
               if (cnt_inc == dbu_pkg::BIT_TICKS)
               begin
                  cnt_nxt = 5'h00;
                  shift_nxt = {rx_level, shift_r[7:1]};
                  bit_nxt = bit_r + 3'h1;
                  // (RQ11) eight bits then parity or stop
                  if (bit_r == dbu_pkg::LAST_DATA_BIT)
                  begin
                     if (fmt_r.parity_select < dbu_pkg::PAR_NONE)
                     begin
                        st_nxt = dbu_pkg::RX_PARITY;
                     end
                     else
                     begin
                        st_nxt = dbu_pkg::RX_STOP;
                     end
                  end
               end
            end
         end
         dbu_pkg::RX_PARITY:
         begin
            if (sample_tick)
            begin
               cnt_nxt = cnt_inc;
               if (cnt_inc == dbu_pkg::BIT_TICKS)
               begin
                  cnt_nxt = 5'h00;
                  par_bit_nxt = rx_level;
                  st_nxt = dbu_pkg::RX_STOP;
               end
            end
         end
         dbu_pkg::RX_STOP:
         begin
            if (sample_tick)
            begin
               cnt_nxt = cnt_inc;
               if (cnt_inc == dbu_pkg::BIT_TICKS)
               begin
                  cnt_nxt = 5'h00;
                  hold_nxt = shift_r;
                  // (RQ16) set wins over read clear
                  flags_nxt.ready = 1'b1;
                  // (RQ14) error detection on each character
                  // (RQ17) overrun when ready still set
                  if (flags_r.ready)
                  begin
                     flags_nxt.overrun = 1'b1;
                  end
                  // (RQ18) parity compare
                  if ((fmt_r.parity_select < dbu_pkg::PAR_NONE) &&
                      (par_bit_r != dbu_pkg::parity_expect(shift_r,
                                       fmt_r.parity_select)))
                  begin
                     flags_nxt.parity_err = 1'b1;
                  end
                  // (RQ19) low stop bit
                  if (!rx_level)
                  begin
                     flags_nxt.frame_err = 1'b1;
                  end
                  // (RQ6) late disable takes effect here
                  if (en_nxt)
                  begin
                     st_nxt = dbu_pkg::RX_HUNT;
                  end
                  else
                  begin
                     st_nxt = dbu_pkg::RX_OFF;
                  end
               end
            end
         end
         default:
         begin
            st_nxt = dbu_pkg::RX_OFF;
         end
      endcase
      // (RQ7) abort overrides the receiver state, but not a same-cycle hold or flag update
      if (cmd_abort)
      begin
         st_nxt = dbu_pkg::RX_OFF;
         en_nxt = 1'b0;
         cnt_nxt = 5'h00;
         bit_nxt = 3'h0;
         shift_nxt = 8'h00;
         par_bit_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      // (RQ4) disabled after reset
      if (!rst_b)
      begin
         st_r <= dbu_pkg::RX_OFF;
         en_r <= 1'b0;
         cnt_r <= 5'h00;
         bit_r <= 3'h0;
         shift_r <= 8'h00;
         par_bit_r <= 1'b0;
         hold_r <= 8'h00;
         flags_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         en_r <= en_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         shift_r <= shift_nxt;
         par_bit_r <= par_bit_nxt;
         hold_r <= hold_nxt;
         flags_r <= flags_nxt;
      end
   end

endmodule

// >>> bench/dbu_props.sv
`timescale 1ns/1ps
module dbu_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial and side outputs
   input wire logic serial_rx_line,
   input wire logic baud_tick,
   input wire logic emulator_test_reset_force
);
   logic acc;
   logic hit;
   logic wfmt;
   logic trst_w;
   logic [7:0] a;
   logic [15:0] div_r;
   logic [15:0] div_nxt;
   logic [2:0] idle_r;
   logic [2:0] idle_nxt;
   assign a = paddr[7:0];
   assign acc = psel && penable;
   assign hit = paddr[31:8] == 24'h000000 && (a == dbu_pkg::CMD_OFS
      || a == dbu_pkg::FMT_OFS || a == dbu_pkg::FLAGS_OFS
      || a == dbu_pkg::RXHOLD_OFS || a == dbu_pkg::DIV_OFS);
   assign wfmt = acc && pwrite && hit && a == dbu_pkg::FMT_OFS;
   assign trst_w = pwdata[dbu_pkg::FORCE_TRST_BIT];
   // divisor shadow, so tick checks know the programmed rate
   always_comb
   begin
      div_nxt = div_r;
      if (acc && pwrite && hit && a == dbu_pkg::DIV_OFS)
         div_nxt = pwdata[15:0];
      idle_nxt = 3'h0;
      if (div_r == 16'h0000)
         idle_nxt = (idle_r == 3'h7) ? idle_r : idle_r + 3'h1;
   end
   always_ff @(posedge clk_sys)
   begin
      div_r <= rst_b ? div_nxt : 16'h0000;
      idle_r <= rst_b ? idle_nxt : 3'h0;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_zero_wait: assert property (acc |-> pready)
      else $error("pready low in access");
   a_bad_addr: assert property (acc && !hit |->
      pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_good_addr: assert property (!(acc && !hit) |-> !pslverr)
      else $error("pslverr without cause");
   a_cmd_reads: assert property (acc && !pwrite && hit &&
      a == dbu_pkg::CMD_OFS |-> prdata == 32'h0)
      else $error("command register read not zero");
   a_trst_write: assert property (wfmt |=>
      emulator_test_reset_force == $past(trst_w))
      else $error("test reset force not written");
   a_trst_hold: assert property (!wfmt |=>
      $stable(emulator_test_reset_force))
      else $error("test reset force moved");
   a_reset_quiet: assert property ($rose(rst_b) |->
      !emulator_test_reset_force && !baud_tick && prdata == 32'h0)
      else $error("outputs not at reset values");
   a_div_zero: assert property (idle_r > 3'h3 |-> !baud_tick)
      else $error("baud tick with zero divisor");
   a_tick_gap: assert property (baud_tick |=> !baud_tick [*8])
      else $error("baud ticks too close");
   a_tick_period: assert property (baud_tick && div_r == 16'h0001
      && $stable(div_r) |-> ##16 (baud_tick || div_r != 16'h0001))
      else $error("bit period not sixteen samples");
endmodule

// >>> bench/dbu_host_model.sv
`timescale 1ns/1ps
module dbu_host_model (
   // clock
   input wire logic clk_sys,
   // line into the port
   output logic serial_rx_line
);
   initial serial_rx_line = 1'b1;
   // start, eight data lsb first, parity, stop
   task automatic send(input logic [7:0] d, input logic pon,
      input logic pb, input logic sb, input int bc);
      logic [10:0] f;
      int n;
      f = pon ? {sb, pb, d, 1'b0} : {1'b1, sb, d, 1'b0};
      n = pon ? 11 : 10;
      for (int i = 0; i < n; i++)
      begin
         serial_rx_line <= f[i];
         // a low stop is cut short so its tail never looks like a start
         repeat ((i == n - 1 && !sb) ? 10 : bc) @(posedge clk_sys);
      end
      serial_rx_line <= 1'b1;
   endtask
   task automatic pulse(input int len);
      serial_rx_line <= 1'b0;
      repeat (len) @(posedge clk_sys);
      serial_rx_line <= 1'b1;
   endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rx_line;
   logic baud_tick;
   logic trst_force;
   logic [31:0] q;
   logic e;
   int err_count = 0;
   int n_checks = 0;
   int ticks;
   always #20 clk_sys = ~clk_sys;
   dbu_host_model host (.clk_sys(clk_sys), .serial_rx_line(rx_line));
   dbu_debug_uart dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_rx_line(rx_line), .baud_tick(baud_tick),
      .emulator_test_reset_force(trst_force));
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask
   task xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // a wait for pready ends once pready is high, or at the watchdog
      do
      begin
         @(posedge clk_sys);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      xfer(1'b1, {24'h0, ad}, d);
   endtask
   task rd(input logic [7:0] ad, input logic [31:0] x);
      xfer(1'b0, {24'h0, ad}, 32'h0);
      chk($sformatf("reg %h", ad), x, q);
   endtask
   task cmd(input int b);
      wr(dbu_pkg::CMD_OFS, 32'h1 << b);
   endtask
   task rx(input logic [7:0] d, input logic pon, input logic pb,
      input logic sb);
      host.send(d, pon, pb, sb, 16);
      repeat (8) @(posedge clk_sys);
   endtask
   function automatic logic [31:0] fl(input logic r, input logic o,
      input logic f, input logic p);
      fl = 32'h0;
      fl[dbu_pkg::READY_BIT] = r;
      fl[dbu_pkg::OVERRUN_BIT] = o;
      fl[dbu_pkg::FRAME_BIT] = f;
      fl[dbu_pkg::PARERR_BIT] = p;
   endfunction
   function automatic logic pbit(input logic [7:0] d, input int s);
      pbit = (s == 0) ? ^d : (s == 1) ? ~^d : (s == 3);
   endfunction
   task t_regs;
      rd(dbu_pkg::FMT_OFS, 32'h0);
      rd(dbu_pkg::DIV_OFS, 32'h0);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
      xfer(1'b0, 32'h00000040, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      wr(dbu_pkg::FLAGS_OFS, 32'hffffffff);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
      rd(dbu_pkg::CMD_OFS, 32'h0);
      wr(dbu_pkg::DIV_OFS, 32'h1);
   endtask
   task t_trst;
      wr(dbu_pkg::FMT_OFS, 32'h1 << dbu_pkg::FORCE_TRST_BIT);
      chk("trst on", 32'h1, {31'h0, trst_force});
      rd(dbu_pkg::FMT_OFS, 32'h1 << dbu_pkg::FORCE_TRST_BIT);
      wr(dbu_pkg::FMT_OFS, 32'h0);
      chk("trst off", 32'h0, {31'h0, trst_force});
   endtask
   task t_enable;
      rx(8'h5a, 1'b1, pbit(8'h5a, 0), 1'b1);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
      cmd(dbu_pkg::RX_ON_BIT);
      rx(8'ha5, 1'b1, pbit(8'ha5, 0), 1'b1);
      rd(dbu_pkg::FLAGS_OFS, fl(1, 0, 0, 0));
      rd(dbu_pkg::RXHOLD_OFS, 32'ha5);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
   endtask
   task t_parity;
      for (int s = 0; s < 4; s++)
      begin
         wr(dbu_pkg::FMT_OFS, 32'(s) << dbu_pkg::PAR_LSB);
         rx(8'h13, 1'b1, pbit(8'h13, s), 1'b1);
         rd(dbu_pkg::FLAGS_OFS, fl(1, 0, 0, 0));
         rd(dbu_pkg::RXHOLD_OFS, 32'h13);
         rx(8'h13, 1'b1, ~pbit(8'h13, s), 1'b1);
         rd(dbu_pkg::FLAGS_OFS, fl(1, 0, 0, 1));
         rd(dbu_pkg::RXHOLD_OFS, 32'h13);
         cmd(dbu_pkg::FLAGS_CLR_BIT);
         rd(dbu_pkg::FLAGS_OFS, 32'h0);
      end
      wr(dbu_pkg::FMT_OFS, 32'(dbu_pkg::PAR_NONE) << dbu_pkg::PAR_LSB);
      rx(8'hc3, 1'b0, 1'b0, 1'b1);
      rd(dbu_pkg::RXHOLD_OFS, 32'hc3);
      wr(dbu_pkg::FMT_OFS, 32'h0);
   endtask
   task t_errors;
      rx(8'h3c, 1'b1, pbit(8'h3c, 0), 1'b0);
      rd(dbu_pkg::FLAGS_OFS, fl(1, 0, 1, 0));
      rd(dbu_pkg::RXHOLD_OFS, 32'h3c);
      rd(dbu_pkg::FLAGS_OFS, fl(0, 0, 1, 0));
      rx(8'h11, 1'b1, pbit(8'h11, 0), 1'b1);
      rx(8'h22, 1'b1, pbit(8'h22, 0), 1'b1);
      rd(dbu_pkg::FLAGS_OFS, fl(1, 1, 1, 0));
      rd(dbu_pkg::RXHOLD_OFS, 32'h22);
      rd(dbu_pkg::FLAGS_OFS, fl(0, 1, 1, 0));
      cmd(dbu_pkg::FLAGS_CLR_BIT);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
   endtask
   task t_glitch;
      host.pulse(7);
      repeat (40) @(posedge clk_sys);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
      rx(8'h69, 1'b1, pbit(8'h69, 0), 1'b1);
      rd(dbu_pkg::RXHOLD_OFS, 32'h69);
   endtask
   task t_stop;
      cmd(dbu_pkg::RX_OFF_BIT);
      rx(8'h77, 1'b1, pbit(8'h77, 0), 1'b1);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
      cmd(dbu_pkg::RX_ON_BIT);
      fork
         host.send(8'h81, 1'b1, pbit(8'h81, 0), 1'b1, 16);
         begin
            repeat (60) @(posedge clk_sys);
            cmd(dbu_pkg::RX_OFF_BIT);
         end
      join
      repeat (8) @(posedge clk_sys);
      rd(dbu_pkg::RXHOLD_OFS, 32'h81);
      rx(8'h42, 1'b1, pbit(8'h42, 0), 1'b1);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
      cmd(dbu_pkg::RX_ON_BIT);
      fork
         host.send(8'h24, 1'b1, pbit(8'h24, 0), 1'b1, 16);
         begin
            repeat (60) @(posedge clk_sys);
            cmd(dbu_pkg::RX_ABORT_BIT);
         end
      join
      repeat (8) @(posedge clk_sys);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
      rd(dbu_pkg::RXHOLD_OFS, 32'h81);
      rx(8'h66, 1'b1, pbit(8'h66, 0), 1'b1);
      rd(dbu_pkg::FLAGS_OFS, 32'h0);
   endtask
   task t_baud;
      for (int d = 2; d >= 0; d--)
      begin
         wr(dbu_pkg::DIV_OFS, 32'(d));
         repeat (40) @(posedge clk_sys);
         ticks = 0;
         repeat (320) @(posedge clk_sys)
            if (baud_tick === 1'b1)
               ticks++;
         chk("baud ticks", (d == 0) ? 0 : 20 / d, ticks);
      end
      wr(dbu_pkg::DIV_OFS, 32'h0000ffff);
      rd(dbu_pkg::DIV_OFS, 32'h0000ffff);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      t_regs;
      t_trst;
      t_enable;
      t_parity;
      t_errors;
      t_glitch;
      t_stop;
      t_baud;
      wrap_up;
   end
   // every test is far shorter than this span
   initial
   begin
      repeat (30000) @(posedge clk_sys);
      err_count++;
      wrap_up;
   end
endmodule
bind dbu_debug_uart dbu_props props (.clk_sys(clk_sys), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_rx_line(serial_rx_line), .baud_tick(baud_tick),
   .emulator_test_reset_force(emulator_test_reset_force));
